// *** src/bmr_consts.vh ***
// constants for the battery mode and alarm register block
// assumes a 200 MHz device clock and an smbus host on the pins
`ifndef BMR_CONSTS_VH
`define BMR_CONSTS_VH

`define BMR_SLAVE_ADDR 7'h0b
`define BMR_CMD_STATUS 8'h00
`define BMR_CMD_LOWCAP 8'h01
`define BMR_CMD_LOWTIME 8'h02
`define BMR_CMD_MODE 8'h03
`define BMR_UNMAPPED 16'hffff
`define BMR_STATUS_LOW 8'h0a

`define BMR_ST_WAKE 4'h0
`define BMR_ST_NORMAL 4'h1
`define BMR_ST_PRECHG 4'h3
`define BMR_ST_SUSP 4'h4
`define BMR_ST_CHARGE 4'h5
`define BMR_ST_TERM 4'h7
`define BMR_ST_FAULT_TERM 4'h8
`define BMR_ST_PERM_FAIL 4'h9
`define BMR_ST_OVERCUR 4'ha
`define BMR_ST_BATT_FAIL 4'hc
`define BMR_ST_SLEEP 4'hd
`define BMR_ST_PRESENT 4'he
`define BMR_ST_OUT 4'hf

`define BMR_TOPO_ZV 2'h0
`define BMR_TOPO_COMMON 2'h1
`define BMR_TOPO_PATH 2'h2

`define BMR_MODE_RELEARN 7
`define BMR_MODE_CTRL_EN 8
`define BMR_MODE_PRIMARY 9
`define BMR_MODE_ALARM_DIS 13
`define BMR_MODE_CHG_BC_DIS 14
`define BMR_MODE_UNITS 15

`define BMR_CLK_PERIOD_PS 5000
`define BMR_TICK_PS 1000000000
`define BMR_TICK_CYC (`BMR_TICK_PS / `BMR_CLK_PERIOD_PS)
`define BMR_HOLD_S 60
`define BMR_HOLD_MS (`BMR_HOLD_S * 1000)
`define BMR_GAP_S 10
`define BMR_GAP_MS (`BMR_GAP_S * 1000)
`define BMR_RELEARN_CYCLES 20

`endif

// *** src/bmr_smb_slave.v ***
// smbus word read/write slave, bit level and byte sequencing
// assumes external pullups; pins are sampled on mclk
`timescale 1ns/1ps
`include "bmr_consts.vh"

module bmr_smb_slave #(
  parameter [6:0] ADDR = `BMR_SLAVE_ADDR
) (
  input wire mclk,
  input wire rst_n,
  input wire smbc_in,
  input wire smbd_in,
  output reg smbd_oe,
  input wire [15:0] rd_data,
  output reg [7:0] cmd_q,
  output reg wr_stb_q,
  output reg [15:0] wr_data_q
);

localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_RX = 3'd1;
localparam [2:0] S_ACK = 3'd2;
localparam [2:0] S_TX = 3'd3;
localparam [2:0] S_TACK = 3'd4;

reg scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
reg [2:0] st_q;
reg [3:0] bitc_q;
reg [7:0] sh_q;
reg [7:0] lo_q;
reg [7:0] hi_q;
reg [7:0] tx_q;
reg [1:0] idx_q;
reg rd_q;

// pins come from another domain: two flops before use
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    scl_s1 <= 1'b1;
    scl_s2 <= 1'b1;
    scl_p <= 1'b1;
    sda_s1 <= 1'b1;
    sda_s2 <= 1'b1;
    sda_p <= 1'b1;
  end
  else
  begin
    scl_s1 <= smbc_in;
    scl_s2 <= scl_s1;
    scl_p <= scl_s2;
    sda_s1 <= smbd_in;
    sda_s2 <= sda_s1;
    sda_p <= sda_s2;
  end
end

wire scl_rise = scl_s2 & ~scl_p;
wire scl_fall = ~scl_s2 & scl_p;
wire start_c = scl_s2 & scl_p & sda_p & ~sda_s2;
wire stop_c = scl_s2 & scl_p & ~sda_p & sda_s2;

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    st_q <= S_IDLE;
    bitc_q <= 4'h0;
    sh_q <= 8'h00;
    lo_q <= 8'h00;
    hi_q <= 8'h00;
    tx_q <= 8'h00;
    idx_q <= 2'h0;
    rd_q <= 1'b0;
    cmd_q <= 8'h00;
    smbd_oe <= 1'b0;
    wr_stb_q <= 1'b0;
    wr_data_q <= 16'h0000;
  end
  else
  begin
    wr_stb_q <= 1'b0;
    if (stop_c)
    begin
      st_q <= S_IDLE;
      smbd_oe <= 1'b0;
    end
    else if (start_c)
    begin
      st_q <= S_RX;
      bitc_q <= 4'h0;
      idx_q <= 2'h0;
      smbd_oe <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_RX:
          if (scl_rise)
          begin
            sh_q <= {sh_q[6:0], sda_s2};
            bitc_q <= bitc_q + 4'h1;
          end
          else if (scl_fall && bitc_q == 4'h8)
          begin
            bitc_q <= 4'h0;
            if (idx_q == 2'h0 && sh_q[7:1] != ADDR)
              st_q <= S_IDLE;
            else
            begin
              st_q <= S_ACK;
              smbd_oe <= 1'b1;
              if (idx_q == 2'h0)
                rd_q <= sh_q[0];
              if (idx_q == 2'h1)
                cmd_q <= sh_q;
              if (idx_q == 2'h2)
                lo_q <= sh_q;
              if (idx_q == 2'h3)
              begin
                wr_stb_q <= 1'b1;
                wr_data_q <= {sh_q, lo_q};
              end
            end
          end
        S_ACK:
          if (scl_fall)
          begin
            // a read address latches the word once, so both bytes agree
            if (rd_q && idx_q == 2'h0)
            begin
              tx_q <= rd_data[7:0];
              hi_q <= rd_data[15:8];
              smbd_oe <= ~rd_data[7];
              idx_q <= 2'h2;
              st_q <= S_TX;
            end
            else
            begin
              smbd_oe <= 1'b0;
              idx_q <= idx_q + 2'h1;
              // no pec: bytes after the word are not acknowledged
              st_q <= (idx_q == 2'h3) ? S_IDLE : S_RX;
            end
          end
        S_TX:
          if (scl_rise)
            bitc_q <= bitc_q + 4'h1;
          else if (scl_fall)
          begin
            if (bitc_q == 4'h8)
            begin
              smbd_oe <= 1'b0;
              bitc_q <= 4'h0;
              st_q <= S_TACK;
            end
            else if (bitc_q == 4'h0)
              smbd_oe <= ~tx_q[7];
            else
            begin
              smbd_oe <= ~tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        S_TACK:
          if (scl_rise)
          begin
            if (!sda_s2 && idx_q == 2'h2)
            begin
              tx_q <= hi_q;
              idx_q <= 2'h3;
              st_q <= S_TX;
            end
            else
              st_q <= S_IDLE;
          end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
end

endmodule // bmr_smb_slave

// *** src/bmr_regs.v ***
// battery mode, alarm threshold and switch state block of a gauge
// assumes gauge core inputs on mclk; smbus pins are asynchronous
`timescale 1ns/1ps
`include "bmr_consts.vh"

module bmr_regs #(
  parameter TICK_CYC = `BMR_TICK_CYC,
  parameter [15:0] HOLD_MS = `BMR_HOLD_MS,
  parameter [15:0] GAP_MS = `BMR_GAP_MS,
  parameter [4:0] RELEARN_CYCLES = `BMR_RELEARN_CYCLES
) (
  input wire mclk,
  input wire rst_n,
  input wire smbc_in,
  input wire smbd_in,
  output reg smbd_out,
  output wire smbd_oe,
  input wire [3:0] state_code,
  input wire [1:0] fail_cause,
  input wire fail_in_charge,
  input wire [1:0] switch_topology_setting,
  input wire fixed_pack_option,
  input wire [15:0] discharge_current,
  input wire [15:0] dsg_detect_threshold,
  input wire [15:0] cfg_low_capacity,
  input wire [15:0] cfg_low_time,
  input wire [15:0] remaining_capacity,
  input wire [15:0] avg_time_to_empty,
  input wire cycle_count_step,
  input wire full_charge_capacity_update,
  input wire learn_done,
  output reg charge_switch,
  output reg discharge_switch,
  output reg zero_volt_precharge_switch,
  output reg precharge_path_switch,
  output reg alarm_send,
  output reg alarm_capacity_flag,
  output reg alarm_time_flag,
  output reg charge_bcast_en,
  output reg capacity_units_10mw,
  output reg [15:0] maker_access_status
);

reg [15:0] low_capacity_threshold_q;
reg [15:0] low_time_threshold_q;
reg relearn_q;
reg ctrl_en_q, primary_role_flag_q;
reg alarm_dis_q, chg_bc_dis_q, units_q;
reg load_q;
reg [3:0] state_prev_q;
reg [31:0] tick_q;
reg tick_ms_q;
reg [15:0] hold_q;
reg [15:0] gap_q;
reg [4:0] stale_q;
reg chg_d, dsg_d, zv_d, path_d;
reg [15:0] rd_data;

wire [7:0] cmd_q;
wire wr_stb_q;
wire [15:0] wr_data_q;
wire [15:0] mode_word;

bmr_smb_slave #(
  .ADDR(`BMR_SLAVE_ADDR)
) u_slave (
  .mclk(mclk),
  .rst_n(rst_n),
  .smbc_in(smbc_in),
  .smbd_in(smbd_in),
  .smbd_oe(smbd_oe),
  .rd_data(rd_data),
  .cmd_q(cmd_q),
  .wr_stb_q(wr_stb_q),
  .wr_data_q(wr_data_q)
);

// bits 6:0 of the low byte read zero; bit 7 reads the relearn flag and is not writable
assign mode_word = {units_q, chg_bc_dis_q, alarm_dis_q, 3'b000,
  primary_role_flag_q, ctrl_en_q, relearn_q, 7'h00};

always @*
begin
  case (cmd_q)
    `BMR_CMD_STATUS: rd_data = maker_access_status;
    `BMR_CMD_LOWCAP: rd_data = low_capacity_threshold_q;
    `BMR_CMD_LOWTIME: rd_data = low_time_threshold_q;
    `BMR_CMD_MODE: rd_data = mode_word;
    default: rd_data = `BMR_UNMAPPED;
  endcase
end

wire mode_wr = wr_stb_q && cmd_q == `BMR_CMD_MODE;
wire sleep_entry = state_code == `BMR_ST_SLEEP &&
  state_prev_q != `BMR_ST_SLEEP;

// thresholds: config loaded in the first cycle after reset release
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    load_q <= 1'b1;
    low_capacity_threshold_q <= 16'h0000;
    low_time_threshold_q <= 16'h0000;
  end
  else
  begin
    load_q <= 1'b0;
    if (load_q)
    begin
      low_capacity_threshold_q <= cfg_low_capacity;
      low_time_threshold_q <= cfg_low_time;
    end
    else if (wr_stb_q)
    begin
      if (cmd_q == `BMR_CMD_LOWCAP)
        low_capacity_threshold_q <= wr_data_q;
      if (cmd_q == `BMR_CMD_LOWTIME)
        low_time_threshold_q <= wr_data_q;
    end
  end
end

// millisecond tick keeps the long timers narrow
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    tick_q <= 32'h0000_0000;
    tick_ms_q <= 1'b0;
  end
  else
  begin
    tick_ms_q <= 1'b0;
    if (tick_q == TICK_CYC - 1)
    begin
      tick_q <= 32'h0000_0000;
      tick_ms_q <= 1'b1;
    end
    else
      tick_q <= tick_q + 32'h0000_0001;
  end
end

// writable mode byte, re-enable timer and sleep defaults
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    ctrl_en_q <= 1'b0;
    primary_role_flag_q <= 1'b0;
    alarm_dis_q <= 1'b0;
    chg_bc_dis_q <= 1'b0;
    units_q <= 1'b0;
    hold_q <= 16'h0000;
    state_prev_q <= `BMR_ST_WAKE;
  end
  else
  begin
    state_prev_q <= state_code;
    if (sleep_entry)
    begin
      alarm_dis_q <= 1'b0;
      chg_bc_dis_q <= 1'b0;
      units_q <= 1'b0;
      hold_q <= 16'h0000;
    end
    else if (mode_wr)
    begin
      // low byte of the written word is dropped without complaint
      ctrl_en_q <= wr_data_q[`BMR_MODE_CTRL_EN];
      primary_role_flag_q <= wr_data_q[`BMR_MODE_PRIMARY];
      alarm_dis_q <= wr_data_q[`BMR_MODE_ALARM_DIS];
      chg_bc_dis_q <= wr_data_q[`BMR_MODE_CHG_BC_DIS];
      units_q <= wr_data_q[`BMR_MODE_UNITS];
      hold_q <= HOLD_MS;
    end
    else if (tick_ms_q && hold_q != 16'h0000)
    begin
      hold_q <= hold_q - 16'h0001;
      if (hold_q == 16'h0001)
        alarm_dis_q <= 1'b0;
    end
  end
end

// relearn request: set wins over the learning-done clear
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    relearn_q <= 1'b1;
    stale_q <= 5'h00;
  end
  else
  begin
    if (full_charge_capacity_update)
      stale_q <= 5'h00;
    else if (cycle_count_step)
      stale_q <= (stale_q == RELEARN_CYCLES - 5'h01) ? 5'h00 :
        stale_q + 5'h01;
    if (cycle_count_step && !full_charge_capacity_update &&
      stale_q == RELEARN_CYCLES - 5'h01)
      relearn_q <= 1'b1;
    else if (learn_done)
      relearn_q <= 1'b0;
  end
end

// alarm detection and rate-limited broadcast request
wire cap_low = low_capacity_threshold_q != 16'h0000 &&
  remaining_capacity < low_capacity_threshold_q;
wire time_low = low_time_threshold_q != 16'h0000 &&
  avg_time_to_empty < low_time_threshold_q;

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    alarm_send <= 1'b0;
    alarm_capacity_flag <= 1'b0;
    alarm_time_flag <= 1'b0;
    gap_q <= 16'h0000;
  end
  else
  begin
    alarm_send <= 1'b0;
    alarm_capacity_flag <= cap_low;
    alarm_time_flag <= time_low;
    if ((cap_low || time_low) && !alarm_dis_q &&
      gap_q == 16'h0000 && !load_q)
    begin
      alarm_send <= 1'b1;
      gap_q <= GAP_MS;
    end
    else if (tick_ms_q && gap_q != 16'h0000)
      gap_q <= gap_q - 16'h0001;
  end
end

// switch states per battery state
always @*
begin
  chg_d = 1'b0;
  dsg_d = 1'b0;
  zv_d = 1'b0;
  path_d = 1'b0;
  case (state_code)
    `BMR_ST_WAKE:
    begin
      chg_d = switch_topology_setting == `BMR_TOPO_COMMON;
      dsg_d = 1'b1;
      zv_d = switch_topology_setting == `BMR_TOPO_ZV ||
        switch_topology_setting == `BMR_TOPO_PATH;
    end
    `BMR_ST_PRECHG:
    begin
      chg_d = switch_topology_setting == `BMR_TOPO_COMMON;
      dsg_d = 1'b1;
      zv_d = switch_topology_setting == `BMR_TOPO_ZV;
      path_d = switch_topology_setting == `BMR_TOPO_PATH;
    end
    `BMR_ST_SUSP, `BMR_ST_TERM, `BMR_ST_FAULT_TERM:
      dsg_d = 1'b1;
    `BMR_ST_CHARGE, `BMR_ST_NORMAL:
    begin
      chg_d = 1'b1;
      dsg_d = 1'b1;
    end
    `BMR_ST_BATT_FAIL, `BMR_ST_OVERCUR:
    begin
      // the switch for the failed direction stays off, except that heavy discharge forces the charge switch on
      chg_d = !fail_in_charge && fixed_pack_option;
      dsg_d = fail_in_charge && fixed_pack_option;
    end
    default:
    begin
      chg_d = 1'b0;
      dsg_d = 1'b0;
    end
  endcase
  if (discharge_current > dsg_detect_threshold)
    chg_d = 1'b1;
end

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    charge_switch <= 1'b0;
    discharge_switch <= 1'b0;
    zero_volt_precharge_switch <= 1'b0;
    precharge_path_switch <= 1'b0;
    charge_bcast_en <= 1'b1;
    capacity_units_10mw <= 1'b0;
    maker_access_status <= 16'h0000;
    smbd_out <= 1'b0;
  end
  else
  begin
    charge_switch <= chg_d;
    discharge_switch <= dsg_d;
    zero_volt_precharge_switch <= zv_d;
    precharge_path_switch <= path_d;
    charge_bcast_en <= !chg_bc_dis_q;
    capacity_units_10mw <= units_q;
    // switch pair in the top bits reflects the registered switches
    maker_access_status <= {~discharge_switch,
      charge_switch ^ discharge_switch, fail_cause, state_code,
      `BMR_STATUS_LOW};
    smbd_out <= 1'b0;
  end
end

endmodule // bmr_regs

// *** testbench/bmr_regs_asserts.sv ***
// checker for the mode and alarm register block
// assumes binding onto bmr_regs; sees its ports only
`timescale 1ns/1ps
module bmr_regs_asserts #(
  parameter TICK_CYC = 10,
  parameter [15:0] GAP_MS = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] state_code,
  input wire logic [1:0] switch_topology_setting,
  input wire logic fixed_pack_option,
  input wire logic [15:0] discharge_current,
  input wire logic [15:0] dsg_detect_threshold,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire logic zero_volt_precharge_switch,
  input wire logic precharge_path_switch,
  input wire logic alarm_send,
  input wire logic alarm_capacity_flag,
  input wire logic alarm_time_flag,
  input wire logic charge_bcast_en,
  input wire logic capacity_units_10mw,
  input wire logic [15:0] maker_access_status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  int gap_q;
  wire heavy = discharge_current > dsg_detect_threshold;
  // saturates so a long quiet spell cannot wrap
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
      gap_q <= 1000000;
    else if (alarm_send)
      gap_q <= 0;
    else if (gap_q < 1000000)
      gap_q <= gap_q + 1;
  a_alarm_gap: assert property (
    alarm_send |-> gap_q >= (GAP_MS - 1) * TICK_CYC - 1)
    else $error("alarm broadcasts too close");
  a_alarm_cause: assert property (
    alarm_send |-> alarm_capacity_flag || alarm_time_flag
    || $past(alarm_capacity_flag) || $past(alarm_time_flag))
    else $error("alarm without low flag");
  a_heavy_chg: assert property (heavy |=> charge_switch)
    else $error("charge switch off under heavy discharge");
  a_wake_zv: assert property (
    state_code == 4'h0 && switch_topology_setting != 2'h1
    |=> zero_volt_precharge_switch && !precharge_path_switch)
    else $error("wake switch pair wrong");
  a_pre_path: assert property (
    state_code == 4'h3 && switch_topology_setting == 2'h2
    |=> !zero_volt_precharge_switch && precharge_path_switch)
    else $error("precharge path switch wrong");
  a_pre_chg: assert property (
    (state_code == 4'h0 || state_code == 4'h3) && !heavy
    |=> charge_switch == ($past(switch_topology_setting) == 2'h1))
    else $error("charge switch topology wrong");
  a_fixed_keep: assert property (
    (state_code == 4'hc || state_code == 4'ha) && fixed_pack_option
    |=> charge_switch || discharge_switch)
    else $error("fixed pack switch not kept");
  a_status_code: assert property (
    $past(rst_n) |->
    maker_access_status[11:0] == {$past(state_code), 8'h0a})
    else $error("status word code wrong");
  a_sleep_clear: assert property (
    state_code == 4'hd && $past(state_code) != 4'hd
    |-> ##[1:3] charge_bcast_en && !capacity_units_10mw)
    else $error("sleep did not clear mode bits");
  c_alarm: cover property (alarm_send);
  c_heavy: cover property (heavy && state_code == 4'hd);
  c_sleep: cover property (state_code == 4'hd && $past(state_code) != 4'hd);
endmodule // bmr_regs_asserts

// *** testbench/bmr_host.sv ***
// smbus host model: word reads and writes on open-drain wires
// assumes pull-ups on both wires; bus clock stands high when idle
`timescale 1ns/1ps
module bmr_host (
  output logic c_lo,
  output logic d_lo,
  input wire logic sda
);
  logic [6:0] addr = 7'h0b;
  initial
  begin
    c_lo = 0;
    d_lo = 0;
  end
  // 48 ns bit; data moves mid low phase, sampled mid high phase
  task automatic bt(input logic b, output logic r);
    #12 d_lo = !b;
    #12 c_lo = 0;
    #12 r = sda;
    #12 c_lo = 1;
  endtask
  task automatic start;
    #12 d_lo = 0;
    #12 c_lo = 0;
    #24 d_lo = 1;
    #24 c_lo = 1;
  endtask
  task automatic stop;
    #12 d_lo = 1;
    #12 c_lo = 0;
    #24 d_lo = 0;
    #24;
  endtask
  task automatic tx(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1, r);
    ok &= !r;
  endtask
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1, v[i]);
    bt(last, r);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
    output logic ok);
    ok = 1;
    start;
    tx({addr, 1'b0}, ok);
    tx(c, ok);
    tx(d[7:0], ok);
    tx(d[15:8], ok);
    stop;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d,
    output logic ok);
    ok = 1;
    start;
    tx({addr, 1'b0}, ok);
    tx(c, ok);
    start;
    tx({addr, 1'b1}, ok);
    rx(0, d[7:0]);
    rx(1, d[15:8]);
    stop;
  endtask
endmodule // bmr_host

// *** testbench/testbench.sv ***
// self-checking bench for the mode and alarm register block
// assumes the host model owns both bus wires; short timer params
`timescale 1ns/1ps
module testbench;
  logic mclk = 0;
  logic rst_n = 0;
  logic [3:0] state_code = 4'h1;
  logic [1:0] fail_cause = 2'h2;
  logic fail_in_charge = 0;
  logic [1:0] switch_topology_setting = 2'h0;
  logic fixed_pack_option = 0;
  logic [15:0] discharge_current = 16'h0000;
  logic [15:0] dsg_detect_threshold = 16'h0100;
  logic [15:0] cfg_low_capacity = 16'h0150;
  logic [15:0] cfg_low_time = 16'h0020;
  logic [15:0] remaining_capacity = 16'hffff;
  logic [15:0] avg_time_to_empty = 16'hffff;
  logic cycle_count_step = 0;
  logic full_charge_capacity_update = 0;
  logic learn_done = 0;
  wire charge_switch, discharge_switch, zero_volt_precharge_switch;
  wire precharge_path_switch, alarm_send, alarm_capacity_flag;
  wire alarm_time_flag, charge_bcast_en, capacity_units_10mw, smbd_oe;
  wire [15:0] maker_access_status;
  wire [1:0] zp_pair = {zero_volt_precharge_switch, precharge_path_switch};
  wire c_lo, d_lo;
  wire smbc_in = !c_lo;
  wire smbd_in = !(d_lo || smbd_oe);
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h9, 4'hd};
  // full status: switch pair, cause 2, code, fixed low byte
  logic [15:0] stat [7] = '{16'h600a, 16'h210a, 16'h630a, 16'h640a,
    16'h250a, 16'ha90a, 16'had0a};
  logic [15:0] d;
  logic ok;
  int fails = 0;
  int num_checks = 0;
  int cnt;
  always #2.5 mclk = ~mclk;
  bmr_host bmr_host_i (.c_lo, .d_lo, .sda(smbd_in));
  bmr_regs #(.TICK_CYC(10), .HOLD_MS(5), .GAP_MS(3), .RELEARN_CYCLES(3))
    bmr_regs_i (.mclk, .rst_n, .smbc_in, .smbd_in, .smbd_out(), .smbd_oe,
    .state_code, .fail_cause, .fail_in_charge, .switch_topology_setting,
    .fixed_pack_option, .discharge_current, .dsg_detect_threshold,
    .cfg_low_capacity, .cfg_low_time, .remaining_capacity,
    .avg_time_to_empty, .cycle_count_step, .full_charge_capacity_update,
    .learn_done, .charge_switch, .discharge_switch,
    .zero_volt_precharge_switch, .precharge_path_switch, .alarm_send,
    .alarm_capacity_flag, .alarm_time_flag, .charge_bcast_en,
    .capacity_units_10mw, .maker_access_status);
  task step;
    @(posedge mclk);
    #1;
  endtask
  task tick;
    step;
    cnt += alarm_send;
  endtask
  task pulse_cc;
    cycle_count_step = 1;
    step;
    cycle_count_step = 0;
    step;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] c, input logic [15:0] exp);
    bmr_host_i.rd(c, d, ok);
    chk(ok, 1);
    chk(d, exp);
  endtask
  task wrc(input logic [7:0] c, input logic [15:0] v, input logic eok);
    bmr_host_i.wr(c, v, ok);
    chk(ok, eok);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    #1 rst_n = 1;
    step;
    rdc(8'h01, 16'h0150);
    rdc(8'h02, 16'h0020);
    rdc(8'h03, 16'h0080);
    chk({charge_bcast_en, capacity_units_10mw}, 2'b10);
    $display("test reset values done");
    wrc(8'h01, 16'h1234, 1);
    rdc(8'h01, 16'h1234);
    wrc(8'h02, 16'h00a5, 1);
    rdc(8'h02, 16'h00a5);
    rdc(8'h07, 16'hffff);
    bmr_host_i.addr = 7'h0c;
    wrc(8'h01, 16'h0000, 0);
    bmr_host_i.addr = 7'h0b;
    rdc(8'h01, 16'h1234);
    $display("test thresholds done");
    wrc(8'h03, 16'hffff, 1);
    remaining_capacity = 16'h0000;
    cnt = 0;
    repeat (20) tick;
    chk(cnt[15:0], 0);
    chk({charge_bcast_en, capacity_units_10mw}, 2'b01);
    repeat (120) tick;
    chk(cnt >= 3 && cnt <= 4, 1);
    chk(alarm_capacity_flag, 1);
    rdc(8'h03, 16'hc380);
    wrc(8'h01, 16'h0000, 1);
    chk(alarm_capacity_flag, 0);
    avg_time_to_empty = 16'h0010;
    repeat (3) step;
    chk(alarm_time_flag, 1);
    wrc(8'h02, 16'h0000, 1);
    chk(alarm_time_flag, 0);
    $display("test mode and alarms done");
    learn_done = 1;
    step;
    learn_done = 0;
    rdc(8'h03, 16'hc300);
    wrc(8'h03, 16'hc3ff, 1);
    rdc(8'h03, 16'hc300);
    repeat (2) pulse_cc;
    full_charge_capacity_update = 1;
    step;
    full_charge_capacity_update = 0;
    repeat (2) pulse_cc;
    rdc(8'h03, 16'hc300);
    pulse_cc;
    rdc(8'h03, 16'hc380);
    state_code = 4'hd;
    repeat (4) step;
    chk({charge_bcast_en, capacity_units_10mw}, 2'b10);
    rdc(8'h03, 16'h0380);
    $display("test relearn and sleep done");
    for (int t = 0; t < 3; t++)
    begin
      switch_topology_setting = t[1:0];
      state_code = 4'h0;
      repeat (2) step;
      chk(charge_switch, t == 1);
      if (t != 1)
        chk(zp_pair, 2'b10);
      state_code = 4'h3;
      repeat (2) step;
      chk(charge_switch, t == 1);
      if (t != 1)
        chk(zp_pair, {t == 0, t == 2});
    end
    state_code = 4'hd;
    discharge_current = 16'h0200;
    repeat (2) step;
    chk(charge_switch, 1);
    discharge_current = 16'h0000;
    for (int k = 0; k < 2; k++)
    begin
      state_code = k ? 4'ha : 4'hc;
      fixed_pack_option = 0;
      fail_in_charge = k[0];
      repeat (2) step;
      chk({charge_switch, discharge_switch}, 2'b00);
      fixed_pack_option = 1;
      repeat (2) step;
      chk({charge_switch, discharge_switch}, {!k[0], k[0]});
    end
    foreach (codes[i])
    begin
      state_code = codes[i];
      repeat (3) step;
      chk(maker_access_status[11:0], {codes[i], 8'h0a});
      chk(maker_access_status, stat[i]);
    end
    rdc(8'h00, 16'had0a);
    $display("test switches and status done");
    summarize;
  end
  initial
  begin
    #300000;
    fails++;
    summarize;
  end
endmodule // testbench
bind bmr_regs bmr_regs_asserts #(.TICK_CYC(TICK_CYC), .GAP_MS(GAP_MS))
  bmr_regs_asserts_i (.mclk, .rst_n, .state_code, .switch_topology_setting,
  .fixed_pack_option, .discharge_current, .dsg_detect_threshold,
  .charge_switch, .discharge_switch, .zero_volt_precharge_switch,
  .precharge_path_switch, .alarm_send, .alarm_capacity_flag,
  .alarm_time_flag, .charge_bcast_en, .capacity_units_10mw,
  .maker_access_status);
